// ---- src/prs_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants for the first loop reference selection block
// Assumes: 40 MHz system clock
// Notes:   Timeouts are derived from the minimum detectable input frequency
//////////////////////////////////////////////////////////////////////////////
package prs_pkg;

  localparam int CLK_PERIOD_PS = 25000;
  localparam int DIV_W         = 12;
  localparam int LOS_CNT_W     = 6;

  // Reference select field encodings
  localparam logic [1:0] SEL_FIX_ZERO = 2'h0;
  localparam logic [1:0] SEL_FIX_ONE  = 2'h1;
  localparam logic [1:0] SEL_AUTO_NR  = 2'h2;
  localparam logic [1:0] SEL_AUTO_RV  = 2'h3;

  // Indicator output format encodings
  localparam logic [1:0] FMT_RESERVED = 2'h0;
  localparam logic [1:0] FMT_NMOS_OD  = 2'h1;
  localparam logic [1:0] FMT_PMOS_OD  = 2'h2;
  localparam logic [1:0] FMT_CMOS     = 2'h3;

  // Minimum detectable input frequency per timeout code, in kHz
  localparam int LOS_MIN_KHZ_0 = 1000;
  localparam int LOS_MIN_KHZ_1 = 3000;
  localparam int LOS_MIN_KHZ_2 = 13000;
  localparam int LOS_MIN_KHZ_3 = 32000;

  // Longest period rounded up to cycles, plus one cycle of margin
  localparam int LOS_CYC_0 =
    (1000000000 / LOS_MIN_KHZ_0 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int LOS_CYC_1 =
    (1000000000 / LOS_MIN_KHZ_1 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int LOS_CYC_2 =
    (1000000000 / LOS_MIN_KHZ_2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int LOS_CYC_3 =
    (1000000000 / LOS_MIN_KHZ_3 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;

  typedef enum logic {PRS_REF_ZERO, PRS_REF_ONE} prs_ref_t;

endpackage

// ---- src/prs_div_if.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Carrier between the selector and one 12-bit divider
// Assumes: Single clock domain
// Notes:   tick is a one-cycle pulse per rising input edge
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
interface prs_div_if;
  logic        tick;
  logic [11:0] ratio;
  logic        out_pulse;
  logic        invalid;

  modport ctrl (output tick, output ratio, input out_pulse, input invalid);
  modport div  (input tick, input ratio, output out_pulse, output invalid);
endinterface

// ---- src/prs_divider.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: 12-bit edge divider, one output pulse per ratio input ticks
// Assumes: Ratio held by the caller, zero is treated as invalid
// Notes:   A ratio lowered mid-count takes effect on the next tick
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module prs_divider #(
  parameter int W = prs_pkg::DIV_W
) (
  input  wire logic CLK,
  input  wire logic RSTN,
  prs_div_if.div    dv
);

  // The carrier fixes the ratio width, so any other width is refused
  if (W != prs_pkg::DIV_W)
  begin : g_bad_width
    $error("prs_divider: width must match the interface");
  end

  logic [W-1:0] cnt_ff;
  logic         pulse_ff;
  logic         invalid_ff;
  logic         hit;

  assign hit = dv.tick && (dv.ratio != '0) && (cnt_ff + 12'h001 >= dv.ratio);

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      cnt_ff <= '0;
    else if (dv.ratio == '0)
      cnt_ff <= '0;
    else if (hit)
      cnt_ff <= '0;
    else if (dv.tick)
      cnt_ff <= cnt_ff + 12'h001;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= hit;   // [RULE_13] [RULE_14]
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      invalid_ff <= 1'b1;
    else
      invalid_ff <= (dv.ratio == '0);   // [RULE_13] [RULE_14]
  end

  assign dv.out_pulse = pulse_ff;
  assign dv.invalid   = invalid_ff;

  a_zero_ratio: assert property (@(posedge CLK) disable iff (!RSTN)
    (dv.ratio == '0) |=> !pulse_ff && invalid_ff)   // [RULE_14]
    else $error("divider pulsed with a zero ratio");

  a_ratio_one: assert property (@(posedge CLK) disable iff (!RSTN)
    (dv.ratio == 12'h001 && dv.tick) |=> pulse_ff)   // [RULE_13]
    else $error("divider by one missed a tick");

endmodule // prs_divider

// ---- src/prs_ref_select.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: First loop reference path: buffer type, input selection,
//          loss-of-signal detection, indicator pins, R and N dividers
// Assumes: Settings come from the serial programming logic on CLK
// Notes:   Reference and feedback pins are sampled at 40 MHz
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01: Bit 0 and bit 1 set MOS buffering for input zero and one, else
//          bipolar differential.
// RULE_02: Select 00 forces input zero, select 01 forces input one.
// RULE_03: Entering either automatic mode starts on input zero.
// RULE_04: Revertive mode uses input zero whenever it is active.
// RULE_05: Non-revertive mode moves only when the selected input fails and
//          the other is active.
// RULE_06: Automatic choices follow the per-input loss states.
// RULE_07: One loss indicator per input, valid only in automatic modes.
// RULE_08: One timeout code sets the minimum frequency of both detectors.
// RULE_09: The host picks a timeout no faster than the real reference.
// RULE_10: Indicator format 00 reserved, 01 NMOS, 10 PMOS, 11 CMOS.
// RULE_11: The host sets format 00 while a fixed input is selected.
// RULE_12: The host starts in select 00 if references may be idle.
// RULE_13: The feedback divider is 12 bits, ratio 1 to 4095, zero invalid.
// RULE_14: The reference divider is 12 bits, ratio 1 to 4095, zero invalid.
// RULE_15: All settings arrive from the serial programming interface.
// RULE_16: The phase detector compares divided reference with divided
//          feedback.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module prs_ref_select (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        REF_INPUT_ZERO,
  input  wire logic        REF_INPUT_ONE,
  input  wire logic        OSC_FEEDBACK,
  input  wire logic [1:0]  REF_INPUT_BUFFER_BITS,
  input  wire logic [1:0]  REF_SELECT_FIELD,
  input  wire logic [1:0]  LOSS_TIMEOUT_SETTING,
  input  wire logic [1:0]  LOSS_FLAG_OUTPUT_FORMAT,
  input  wire logic [11:0] FIRST_LOOP_REFERENCE_DIVIDER,
  input  wire logic [11:0] FIRST_LOOP_FEEDBACK_DIVIDER,
  output logic      [1:0]  REF_BUFFER_TYPE_MOS,
  output logic             REF_SELECTED_ONE,
  output logic      [1:0]  LOSS_STATE,
  output logic      [1:0]  LOSS_FLAG_O,
  output logic      [1:0]  LOSS_FLAG_OE_N,
  output logic             PD_REF_PULSE,
  output logic             PD_FB_PULSE,
  output logic             PD_UP,
  output logic             PD_DOWN,
  output logic             REF_DIV_INVALID,
  output logic             FB_DIV_INVALID
);

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  //////////////////////////////////////////////////////////////////////////
  // Settings capture
  logic [1:0]  buf_ff;
  logic [1:0]  sel_cfg_ff;
  logic [1:0]  tmo_ff;
  logic [1:0]  fmt_ff;
  logic [11:0] rdiv_ff;
  logic [11:0] ndiv_ff;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      buf_ff     <= 2'h0;
      sel_cfg_ff <= prs_pkg::SEL_FIX_ZERO;
      tmo_ff     <= 2'h0;
      fmt_ff     <= prs_pkg::FMT_RESERVED;
      rdiv_ff    <= 12'h000;
      ndiv_ff    <= 12'h000;
    end
    else
    begin
      buf_ff     <= REF_INPUT_BUFFER_BITS;          // [RULE_15]
      sel_cfg_ff <= REF_SELECT_FIELD;               // [RULE_15]
      tmo_ff     <= LOSS_TIMEOUT_SETTING;           // [RULE_15]
      fmt_ff     <= LOSS_FLAG_OUTPUT_FORMAT;        // [RULE_15]
      rdiv_ff    <= FIRST_LOOP_REFERENCE_DIVIDER;
      ndiv_ff    <= FIRST_LOOP_FEEDBACK_DIVIDER;
    end
  end

  // Bit n drives the buffer mode of input n
  assign REF_BUFFER_TYPE_MOS = buf_ff;   // [RULE_01]

  //////////////////////////////////////////////////////////////////////////
  // Input sampling and loss detection, one slice per input
  logic [1:0] pin_raw;
  logic [1:0] edge_seen;
  localparam int LOS_CNT_W_L = prs_pkg::LOS_CNT_W;
  logic [1:0] lost_ff;
  logic [LOS_CNT_W_L-1:0] tmo_cyc;

  assign pin_raw = {REF_INPUT_ONE, REF_INPUT_ZERO};

  // A 32 MHz input is near the sampling limit, so short codes are coarse
  always_comb
  begin
    case (tmo_ff)   // [RULE_08]
      2'h0:    tmo_cyc = LOS_CNT_W_L'(prs_pkg::LOS_CYC_0);
      2'h1:    tmo_cyc = LOS_CNT_W_L'(prs_pkg::LOS_CYC_1);
      2'h2:    tmo_cyc = LOS_CNT_W_L'(prs_pkg::LOS_CYC_2);
      default: tmo_cyc = LOS_CNT_W_L'(prs_pkg::LOS_CYC_3);
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_los
      logic                   s1_ff;
      logic                   s2_ff;
      logic                   s3_ff;
      logic [LOS_CNT_W_L-1:0] cnt_ff;

      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end
        else
        begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end

      assign edge_seen[gi] = s2_ff && !s3_ff;

      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
          cnt_ff <= '0;
        else if (edge_seen[gi])
          cnt_ff <= '0;
        else if (cnt_ff < tmo_cyc)
          cnt_ff <= cnt_ff + LOS_CNT_W_L'(1);
      end

      // Idle until the first edge: no reference counts as lost
      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
          lost_ff[gi] <= 1'b1;
        else if (edge_seen[gi])
          lost_ff[gi] <= 1'b0;
        else if (cnt_ff >= tmo_cyc)
          lost_ff[gi] <= 1'b1;   // [RULE_08]
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Reference selection
  prs_pkg::prs_ref_t sel_ff;
  prs_pkg::prs_ref_t nxt_sel;
  logic              auto_mode;
  logic              prev_auto_ff;

  assign auto_mode = sel_cfg_ff[1];

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      prev_auto_ff <= 1'b0;
    else
      prev_auto_ff <= auto_mode;
  end

  always_comb
  begin
    nxt_sel = sel_ff;
    case (sel_cfg_ff)
      prs_pkg::SEL_FIX_ZERO: nxt_sel = prs_pkg::PRS_REF_ZERO;   // [RULE_02]
      prs_pkg::SEL_FIX_ONE:  nxt_sel = prs_pkg::PRS_REF_ONE;    // [RULE_02]
      prs_pkg::SEL_AUTO_RV:
      begin
        if (!prev_auto_ff || !lost_ff[0])
          nxt_sel = prs_pkg::PRS_REF_ZERO;   // [RULE_03] [RULE_04] [RULE_06]
        else
          nxt_sel = prs_pkg::PRS_REF_ONE;    // [RULE_04]
      end
      prs_pkg::SEL_AUTO_NR:
      begin
        if (!prev_auto_ff)
          nxt_sel = prs_pkg::PRS_REF_ZERO;   // [RULE_03]
        else if (sel_ff == prs_pkg::PRS_REF_ZERO && lost_ff[0] && !lost_ff[1])
          nxt_sel = prs_pkg::PRS_REF_ONE;    // [RULE_05] [RULE_06]
        else if (sel_ff == prs_pkg::PRS_REF_ONE && lost_ff[1] && !lost_ff[0])
          nxt_sel = prs_pkg::PRS_REF_ZERO;   // [RULE_05] [RULE_06]
      end
      default: nxt_sel = prs_pkg::PRS_REF_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      sel_ff <= prs_pkg::PRS_REF_ZERO;
    else
      sel_ff <= nxt_sel;
  end

  assign REF_SELECTED_ONE = (sel_ff == prs_pkg::PRS_REF_ONE);

  //////////////////////////////////////////////////////////////////////////
  // Loss indicator pins; released outside automatic modes
  logic [1:0] flag_o_ff;
  logic [1:0] flag_oe_n_ff;
  logic [1:0] state_ff;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_flag
      always_ff @(posedge CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          state_ff[gi]     <= 1'b0;
          flag_o_ff[gi]    <= 1'b0;
          flag_oe_n_ff[gi] <= 1'b1;
        end
        else
        begin
          state_ff[gi] <= auto_mode && lost_ff[gi];   // [RULE_07]
          if (!auto_mode)
          begin
            flag_o_ff[gi]    <= 1'b0;                 // [RULE_07]
            flag_oe_n_ff[gi] <= 1'b1;
          end
          else
          begin
            case (fmt_ff)   // [RULE_10]
              prs_pkg::FMT_NMOS_OD:
              begin
                flag_o_ff[gi]    <= 1'b0;
                flag_oe_n_ff[gi] <= lost_ff[gi];
              end
              prs_pkg::FMT_PMOS_OD:
              begin
                flag_o_ff[gi]    <= 1'b1;
                flag_oe_n_ff[gi] <= !lost_ff[gi];
              end
              prs_pkg::FMT_CMOS:
              begin
                flag_o_ff[gi]    <= lost_ff[gi];
                flag_oe_n_ff[gi] <= 1'b0;
              end
              default:
              begin
                flag_o_ff[gi]    <= 1'b0;
                flag_oe_n_ff[gi] <= 1'b1;
              end
            endcase
          end
        end
      end
    end
  endgenerate

  assign LOSS_STATE     = state_ff;
  assign LOSS_FLAG_O    = flag_o_ff;
  assign LOSS_FLAG_OE_N = flag_oe_n_ff;

  //////////////////////////////////////////////////////////////////////////
  // Dividers and phase detector
  logic fb_s1_ff;
  logic fb_s2_ff;
  logic fb_s3_ff;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fb_s1_ff <= 1'b0;
      fb_s2_ff <= 1'b0;
      fb_s3_ff <= 1'b0;
    end
    else
    begin
      fb_s1_ff <= OSC_FEEDBACK;
      fb_s2_ff <= fb_s1_ff;
      fb_s3_ff <= fb_s2_ff;
    end
  end

  prs_div_if rdiv_if ();
  prs_div_if ndiv_if ();

  assign rdiv_if.tick  = edge_seen[sel_ff == prs_pkg::PRS_REF_ONE];  // [RULE_16]
  assign rdiv_if.ratio = rdiv_ff;
  assign ndiv_if.tick  = fb_s2_ff && !fb_s3_ff;
  assign ndiv_if.ratio = ndiv_ff;

  prs_divider u_rdiv (.CLK(CLK), .RSTN(RSTN), .dv(rdiv_if));
  prs_divider u_ndiv (.CLK(CLK), .RSTN(RSTN), .dv(ndiv_if));

  assign REF_DIV_INVALID = rdiv_if.invalid;
  assign FB_DIV_INVALID  = ndiv_if.invalid;

  logic up_ff;
  logic dn_ff;
  logic refp_ff;
  logic fbp_ff;

  // Both flags meeting clears them, as a frequency-phase detector does
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      up_ff   <= 1'b0;
      dn_ff   <= 1'b0;
      refp_ff <= 1'b0;
      fbp_ff  <= 1'b0;
    end
    else
    begin
      refp_ff <= rdiv_if.out_pulse;
      fbp_ff  <= ndiv_if.out_pulse;
      up_ff   <= (up_ff || rdiv_if.out_pulse) &&
                 !(dn_ff || ndiv_if.out_pulse);   // [RULE_16]
      dn_ff   <= (dn_ff || ndiv_if.out_pulse) &&
                 !(up_ff || rdiv_if.out_pulse);   // [RULE_16]
    end
  end

  assign PD_REF_PULSE = refp_ff;
  assign PD_FB_PULSE  = fbp_ff;
  assign PD_UP        = up_ff;
  assign PD_DOWN      = dn_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_enter_auto;
    !auto_mode ##1 auto_mode;
  endsequence

  a_auto_start: assert property (s_enter_auto |=>   // [RULE_03]
    sel_ff == prs_pkg::PRS_REF_ZERO)
    else $error("automatic mode did not start on input zero");

  a_fixed_zero: assert property (   // [RULE_02]
    sel_cfg_ff == prs_pkg::SEL_FIX_ZERO |=> !REF_SELECTED_ONE)
    else $error("fixed zero not selected");

  a_fixed_one: assert property (   // [RULE_02]
    sel_cfg_ff == prs_pkg::SEL_FIX_ONE |=> REF_SELECTED_ONE)
    else $error("fixed one not selected");

  a_revert_pick: assert property (   // [RULE_04]
    sel_cfg_ff == prs_pkg::SEL_AUTO_RV && prev_auto_ff
    |=> REF_SELECTED_ONE == $past(lost_ff[0]))
    else $error("revertive choice wrong");

  a_nonrev_hold: assert property (   // [RULE_05]
    sel_cfg_ff == prs_pkg::SEL_AUTO_NR && prev_auto_ff &&
    !lost_ff[sel_ff == prs_pkg::PRS_REF_ONE] |=> $stable(sel_ff))
    else $error("non-revertive switched without failure");

  a_flag_idle: assert property (!auto_mode |=> &LOSS_FLAG_OE_N   // [RULE_07]
    && LOSS_STATE == 2'h0)
    else $error("indicator driven outside automatic mode");

  a_loss_timeout: assert property (   // [RULE_08]
    (tmo_ff == 2'h3 && !edge_seen[0]) [*4]
    |=> lost_ff[0])
    else $error("loss not flagged after timeout");

  a_pd_exclusive: assert property (!(up_ff && dn_ff))   // [RULE_16]
    else $error("both detector flags high");

endmodule // prs_ref_select

// ---- verification/prs_ref_src.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Reference or feedback clock source facing the block
// Assumes: Half period in ns, a multiple of the 25 ns bench clock
// Notes:   A stopped source parks low, as a dead reference would
`timescale 1ns/1ps
module prs_ref_src (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             pin
);
  initial pin = 1'b0;
  // Rate is set by half_ns alone, whatever minimum is programmed
  always
  begin
    if (run)
    begin
      #(half_ns) pin = ~pin;
    end
    else
    begin
      pin = 1'b0;
      #(half_ns);
    end
  end
endmodule // prs_ref_src

// ---- verification/testbench.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the first loop reference path
// Assumes: Sources toggle on falling clock edges, so syncing is exact
// Notes:   Periods are 8, 12 and 6 clocks for ref zero, ref one, feedback
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        run0 = 1'b0;
  logic        run1 = 1'b0;
  logic        ref0;
  logic        ref1;
  logic        fb;
  logic [1:0]  buf_bits = 2'h0;
  logic [1:0]  sel = 2'h0;
  logic [1:0]  tmo = 2'h1;
  logic [1:0]  fmt = 2'h0;
  logic [11:0] rdiv = 12'h000;
  logic [11:0] ndiv = 12'h000;
  logic [1:0]  mos;
  logic        sel_one;
  logic [1:0]  loss;
  logic [1:0]  flag_o;
  logic [1:0]  flag_oe_n;
  logic        pd_ref;
  logic        pd_fb;
  logic        pd_up;
  logic        pd_dn;
  logic        r_inv;
  logic        n_inv;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          exp_sel = 0;
  int          cnt;

  always #12.5 clk = ~clk;

  prs_ref_src src0 (.run(run0), .pin(ref0), .half_ns(16'h0064));
  prs_ref_src src1 (.run(run1), .pin(ref1), .half_ns(16'h0096));
  prs_ref_src srcf (.run(1'b1), .pin(fb), .half_ns(16'h004B));

  prs_ref_select DUT (
    .CLK(clk), .RSTN(rstn), .REF_INPUT_ZERO(ref0), .REF_INPUT_ONE(ref1),
    .OSC_FEEDBACK(fb), .REF_INPUT_BUFFER_BITS(buf_bits),
    .REF_SELECT_FIELD(sel), .LOSS_TIMEOUT_SETTING(tmo),
    .LOSS_FLAG_OUTPUT_FORMAT(fmt), .FIRST_LOOP_REFERENCE_DIVIDER(rdiv),
    .FIRST_LOOP_FEEDBACK_DIVIDER(ndiv), .REF_BUFFER_TYPE_MOS(mos),
    .REF_SELECTED_ONE(sel_one), .LOSS_STATE(loss), .LOSS_FLAG_O(flag_o),
    .LOSS_FLAG_OE_N(flag_oe_n), .PD_REF_PULSE(pd_ref),
    .PD_FB_PULSE(pd_fb), .PD_UP(pd_up), .PD_DOWN(pd_dn),
    .REF_DIV_INVALID(r_inv), .FB_DIV_INVALID(n_inv)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Selector model; auto entry resets the choice to input zero in cfg
  function automatic int model_sel(int m, int prev, int l0, int l1);
    if (m < 2)
      return m;
    if (m == 3)
      return l0;
    if (prev == 0 && l0 && !l1)
      return 1;
    if (prev == 1 && l1 && !l0)
      return 0;
    return prev;
  endfunction

  // Pin drive per format for loss bits l: {O, OE_N}
  function automatic logic [11:0] flags(int f, logic [1:0] l);
    case (f)
      1: return {8'h00, 2'h0, l};
      2: return {8'h00, 2'h3, ~l};
      3: return {8'h00, l, 2'h0};
      default: return 12'h003;
    endcase
  endfunction

  function automatic logic [11:0] probe(int k);
    case (k)
      0: return {11'h000, sel_one};
      1: return {10'h000, loss};
      2: return {8'h00, flag_o, flag_oe_n};
      default: return {10'h000, r_inv, n_inv};
    endcase
  endfunction

  // Levels settle through synchronisers and timeouts, so poll bounded
  task automatic wait_for(input int k, input logic [11:0] exp,
                          input string what);
    int n;
    n = 0;
    while (probe(k) !== exp && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    check(probe(k), exp, what);
    if (n >= 60)
      finish_test();
  endtask

  task automatic cfg(input logic [1:0] s, input logic [1:0] f);
    @(negedge clk);
    if (s[1] && !sel[1])
      exp_sel = 0;
    sel = s;
    fmt = f;
  endtask

  task automatic follow(input string what);
    exp_sel = model_sel(sel, exp_sel, !run0, !run1);
    wait_for(0, exp_sel, what);
  endtask

  // Cycles between two detector pulses of one path
  task automatic gap(input bit which, input int exp, input string what);
    int t;
    for (int n = 0; n < 2; n++)
    begin
      @(negedge clk);
      t = 1;
      while ((which ? pd_fb : pd_ref) !== 1'b1 && t < 400)
      begin
        @(negedge clk);
        t++;
      end
    end
    check(t, exp, what);
    check({11'h000, pd_up & pd_dn}, 12'h000, "detector flags");
    if (t >= 400)
      finish_test();
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hD9D4));
    repeat (20) @(negedge clk);
    check(probe(2), 12'h003, "reset pins");
    check(probe(3), 12'h003, "reset invalid");
    rstn = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      buf_bits = i[1:0];
      repeat (2) @(negedge clk);
      check({10'h000, mos}, i, "buffer type");
    end
    run0 = 1'b1;
    run1 = 1'b1;
    // Fixed input one holds even after that input dies
    cfg(2'h1, 2'h0);
    follow("fixed one");
    run1 = 1'b0;
    repeat (50) @(negedge clk);
    check({11'h000, sel_one}, 12'h001, "fixed one");
    check(probe(1), 12'h000, "fixed loss");
    check(probe(2), 12'h003, "fixed pins");
    cfg(2'h0, 2'h0);
    follow("fixed zero");
    run1 = 1'b1;
    // Revertive
    cfg(2'h3, 2'h3);
    follow("auto entry");
    wait_for(1, 12'h000, "loss");
    run0 = 1'b0;
    wait_for(1, 12'h001, "loss");
    follow("revertive");
    for (int f = 0; f < 4; f++)
    begin
      cfg(2'h3, f[1:0]);
      wait_for(2, flags(f, 2'h1), "loss pins");
    end
    run0 = 1'b1;
    wait_for(1, 12'h000, "loss");
    follow("revertive");
    // Non-revertive
    cfg(2'h0, 2'h0);
    follow("fixed zero");
    cfg(2'h2, 2'h3);
    follow("auto entry");
    run0 = 1'b0;
    wait_for(1, 12'h001, "loss");
    follow("non-revertive");
    run0 = 1'b1;
    wait_for(1, 12'h000, "loss");
    repeat (50) @(negedge clk);
    follow("non-revertive");
    run1 = 1'b0;
    wait_for(1, 12'h002, "loss");
    follow("non-revertive");
    run1 = 1'b1;
    // Too high a minimum gives false loss on both inputs
    for (int c = 0; c < 4; c++)
    begin
      @(negedge clk);
      tmo = c[1:0];
      wait_for(1, c[1] ? 12'h003 : 12'h000, "timeout");
    end
    tmo = 2'h1;
    // Dividers on each selected input; ratio 1 is the boundary
    for (int k = 0; k < 2; k++)
    begin
      cfg({1'b0, k[0]}, 2'h0);
      rdiv = k ? 12'($urandom_range(6, 1)) : 12'h001;
      ndiv = 12'($urandom_range(6, 1));
      repeat (100) @(negedge clk);
      gap(1'b0, (k ? 12 : 8) * rdiv, "ref gap");
      gap(1'b1, 6 * ndiv, "fb gap");
    end
    rdiv = 12'h000;
    ndiv = 12'h000;
    wait_for(3, 12'h003, "invalid");
    cnt = 0;
    repeat (100)
    begin
      @(negedge clk);
      cnt += pd_ref | pd_fb;
    end
    check(cnt, 12'h000, "zero ratio");
    finish_test();
  end
endmodule // testbench
